// ===== logic/ipbm_prio_bank.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module ipbm_prio_bank #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire ipbm_pkg::ipbm_bus_t bus,
  input wire logic [ipbm_pkg::NUM_SRC-1:0] srcPending,
  input wire logic [ipbm_pkg::NUM_SRC-1:0] srcEnable,
  input wire logic [2:0] canTxPriority,
  output logic [15:0] rdata,
  output logic [ipbm_pkg::NUM_REGS-1:0][15:0] prioRegs,
  output logic reqValid,
  output logic [4:0] reqId,
  output logic [2:0] reqLevel
);

  // implemented-bit mask of a register index
  function automatic logic [15:0] implMask(input logic [2:0] idx);
    case (idx)
      ipbm_pkg::IDX_DMA1_ADC_UART1TX: implMask = ipbm_pkg::MASK_DMA1_ADC_UART1TX;
      ipbm_pkg::IDX_CAPTURE_EXT1: implMask = ipbm_pkg::MASK_CAPTURE_EXT1;
      ipbm_pkg::IDX_PINCHANGE_CMP_I2C,
      ipbm_pkg::IDX_TIMER4_COMPARE_DMA2,
      ipbm_pkg::IDX_UART2_EXT2_TIMER5,
      ipbm_pkg::IDX_CAN_SPI2: implMask = ipbm_pkg::MASK_FOUR_FIELDS;
      default: implMask = 16'h0000;
    endcase
  endfunction

  // one 3-bit field of a register
  function automatic logic [2:0] field(input logic [15:0] r, input int pos);
    field = r[pos +: 3];
  endfunction

  ipbm_pkg::ipbm_state_t s_q;
  ipbm_pkg::ipbm_state_t s_d;
  logic [ipbm_pkg::NUM_SRC-1:0][2:0] level;

  // flatten fields into per-source levels
  always_comb begin
    level[0] = field(s_q.regs[0], ipbm_pkg::POS_MH);
    level[1] = field(s_q.regs[0], ipbm_pkg::POS_ML);
    level[2] = field(s_q.regs[0], ipbm_pkg::POS_LO);
    level[3] = field(s_q.regs[1], ipbm_pkg::POS_HI);
    level[4] = field(s_q.regs[1], ipbm_pkg::POS_MH);
    level[5] = field(s_q.regs[1], ipbm_pkg::POS_ML);
    level[6] = field(s_q.regs[1], ipbm_pkg::POS_LO);
    level[7] = field(s_q.regs[2], ipbm_pkg::POS_HI);
    level[8] = field(s_q.regs[2], ipbm_pkg::POS_MH);
    level[9] = field(s_q.regs[2], ipbm_pkg::POS_LO);
    level[10] = field(s_q.regs[3], ipbm_pkg::POS_HI);
    level[11] = field(s_q.regs[3], ipbm_pkg::POS_MH);
    level[12] = field(s_q.regs[3], ipbm_pkg::POS_ML);
    level[13] = field(s_q.regs[3], ipbm_pkg::POS_LO);
    level[14] = field(s_q.regs[4], ipbm_pkg::POS_HI);
    level[15] = field(s_q.regs[4], ipbm_pkg::POS_MH);
    level[16] = field(s_q.regs[4], ipbm_pkg::POS_ML);
    level[17] = field(s_q.regs[4], ipbm_pkg::POS_LO);
    level[18] = field(s_q.regs[5], ipbm_pkg::POS_ML);
    level[19] = field(s_q.regs[5], ipbm_pkg::POS_LO);
    level[20] = field(s_q.regs[5], ipbm_pkg::POS_HI);
    level[21] = field(s_q.regs[5], ipbm_pkg::POS_MH);
    level[22] = canTxPriority;
  end

  // next state: register writes, read data, arbitration
  always_comb begin
    logic [2:0] best;
    logic [4:0] bestId;
    logic found;
    logic live;
    best = ipbm_pkg::PRIO_OFF;
    bestId = 5'h00;
    found = 1'b0;
    live = 1'b0;
    s_d = s_q;
    s_d.mode = ipbm_pkg::IPBM_RUN;
    s_d.rdata = 16'h0000;
    if (bus.wr && bus.addr < 3'(ipbm_pkg::NUM_REGS)) begin
      s_d.regs[bus.addr] = bus.wdata & implMask(bus.addr);
    end
    if (bus.rd && bus.addr < 3'(ipbm_pkg::NUM_REGS)) begin
      s_d.rdata = s_q.regs[bus.addr] & implMask(bus.addr);
    end
    for (int i = 0; i < ipbm_pkg::NUM_SRC; i++) begin
      live = srcPending[i] && srcEnable[i];
      live = live && (level[i] != ipbm_pkg::PRIO_OFF);
      if (i >= ipbm_pkg::SRC_CAN_EVENT && !HAS_CAN) begin
        live = 1'b0;
      end
      if (live && (!found || level[i] > best)) begin
        best = level[i];
        bestId = 5'(i);
        found = 1'b1;
      end
    end
    s_d.reqValid = found;
    s_d.reqId = bestId;
    s_d.reqLevel = best;
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_q.regs[0] <= ipbm_pkg::RESET_FOUR_FIELDS & ipbm_pkg::MASK_DMA1_ADC_UART1TX;
      s_q.regs[1] <= ipbm_pkg::RESET_FOUR_FIELDS;
      s_q.regs[2] <= ipbm_pkg::RESET_FOUR_FIELDS & ipbm_pkg::MASK_CAPTURE_EXT1;
      s_q.regs[3] <= ipbm_pkg::RESET_FOUR_FIELDS;
      s_q.regs[4] <= ipbm_pkg::RESET_FOUR_FIELDS;
      s_q.regs[5] <= ipbm_pkg::RESET_FOUR_FIELDS;
      s_q.rdata <= 16'h0000;
      s_q.reqValid <= 1'b0;
      s_q.reqId <= 5'h00;
      s_q.reqLevel <= 3'h0;
      s_q.mode <= ipbm_pkg::IPBM_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign prioRegs = s_q.regs;
  assign reqValid = s_q.reqValid;
  assign reqId = s_q.reqId;
  assign reqLevel = s_q.reqLevel;

endmodule // ipbm_prio_bank

// ===== pkg/ipbm_pkg.sv
package ipbm_pkg;
  // register indices (word addresses on the plain port)
  localparam logic [2:0] IDX_DMA1_ADC_UART1TX = 3'h0;
  localparam logic [2:0] IDX_PINCHANGE_CMP_I2C = 3'h1;
  localparam logic [2:0] IDX_CAPTURE_EXT1 = 3'h2;
  localparam logic [2:0] IDX_TIMER4_COMPARE_DMA2 = 3'h3;
  localparam logic [2:0] IDX_UART2_EXT2_TIMER5 = 3'h4;
  localparam logic [2:0] IDX_CAN_SPI2 = 3'h5;
  localparam int NUM_REGS = 6;
  // field positions (low bit of each 3-bit field)
  localparam int POS_HI = 12;
  localparam int POS_MH = 8;
  localparam int POS_ML = 4;
  localparam int POS_LO = 0;
  // implemented-bit masks per register
  localparam logic [15:0] MASK_DMA1_ADC_UART1TX = 16'h0777;
  localparam logic [15:0] MASK_FOUR_FIELDS = 16'h7777;
  localparam logic [15:0] MASK_CAPTURE_EXT1 = 16'h7707;
  // reset value of every field is level 4
  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [15:0] RESET_FOUR_FIELDS = 16'h4444;
  // source count and can source indices in the flat vector
  localparam int NUM_SRC = 23;
  localparam int SRC_CAN_EVENT = 20;
  localparam int SRC_CAN_RX = 21;
  localparam int SRC_CAN_TX = 22;
  localparam logic [2:0] PRIO_OFF = 3'h0;

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ipbm_bus_t;

  typedef enum logic [1:0] {
    IPBM_IDLE = 2'b00,
    IPBM_RUN = 2'b01
  } ipbm_mode_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][15:0] regs;
    logic [15:0] rdata;
    logic reqValid;
    logic [4:0] reqId;
    logic [2:0] reqLevel;
    ipbm_mode_t mode;
  } ipbm_state_t;
endpackage

// ===== sim/ipbm_prio_bank_sva.sv
`timescale 1ns/1ps
module ipbm_prio_bank_sva #(parameter bit HAS_CAN = 1'b1) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire ipbm_pkg::ipbm_bus_t bus,
  input wire logic [22:0] srcPending,
  input wire logic [22:0] srcEnable,
  input wire logic [15:0] rdata,
  input wire logic [5:0][15:0] prioRegs,
  input wire logic reqValid,
  input wire logic [4:0] reqId,
  input wire logic [2:0] reqLevel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [22:0] live_q;
  // live sources of last cycle
  always_ff @(posedge core_clk) live_q <= srcPending & srcEnable;
  property rdP;
    logic [15:0] v;
    (bus.rd && bus.addr < 3'h6, v = prioRegs[bus.addr]) |=> rdata == v;
  endproperty
  property wrP;
    logic [2:0] a;
    (bus.wr && bus.addr < 3'h6, a = bus.addr) |=> prioRegs[a] == ($past(bus.wdata) &
      (a == 3'h0 ? 16'h0777 : (a == 3'h2 ? 16'h7707 : 16'h7777)));
  endproperty
  rd_data_a: assert property (rdP) else $error("bad read data");
  rd_zero_a: assert property (!(bus.rd && bus.addr < 3'h6) |=> rdata == 16'h0)
    else $error("rdata not zero");
  wr_mask_a: assert property (wrP) else $error("bad write");
  unmap_wr_a: assert property (bus.wr && bus.addr > 3'h5 |=> $stable(prioRegs))
    else $error("unmapped write landed");
  reset_val_a: assert property ($rose(rstn) |->
    prioRegs == {{3{16'h4444}}, 16'h4404, 16'h4444, 16'h0444}) else $error("bad reset");
  win_live_a: assert property (reqValid |-> live_q[reqId] && reqLevel != 3'h0)
    else $error("dead winner");
  idle_none_a: assert property (live_q == 23'h0 |-> !reqValid)
    else $error("request with none live");
  can_off_a: assert property (!HAS_CAN && reqValid |-> reqId < 5'd20)
    else $error("can source won");
  cover property (bus.wr && bus.addr > 3'h5);
  cover property (reqValid && reqLevel == 3'h7);
  cover property (bus.wr ##1 bus.rd);
endmodule // ipbm_prio_bank_sva
bind ipbm_prio_bank ipbm_prio_bank_sva #(.HAS_CAN(HAS_CAN)) u_sva (.core_clk, .rstn, .bus,
  .srcPending, .srcEnable, .rdata, .prioRegs, .reqValid, .reqId, .reqLevel);

// ===== sim/interrupt_priority_bank_mid_tb.sv
`timescale 1ns/1ps
module interrupt_priority_bank_mid_tb;
  logic core_clk;
  logic rstn = 1'b0;
  ipbm_pkg::ipbm_bus_t bus = '0;
  logic [22:0] srcPending = '0;
  logic [22:0] srcEnable = '0;
  logic [2:0] canTxPriority = 3'h0;
  logic [15:0] rdata;
  logic [5:0][15:0] prioRegs;
  logic reqValid;
  logic [4:0] reqId;
  logic [2:0] reqLevel;
  logic [5:0][15:0] mir = {{3{16'h4444}}, 16'h4404, 16'h4444, 16'h0444};
  logic [15:0] er = 16'h0;
  logic [8:0] e = 9'h0;
  int seed = 97;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int r;
  // register and slot of each source field
  localparam logic [0:21][7:0] PLACE = 176'h02010013121110232220333231304342414051505352;
  ipbm_prio_bank dut (.core_clk, .rstn, .bus, .srcPending, .srcEnable, .canTxPriority,
    .rdata, .prioRegs, .reqValid, .reqId, .reqLevel);
  ipbm_prio_bank #(.HAS_CAN(1'b0)) dut2 (.core_clk, .rstn, .bus, .srcPending, .srcEnable,
    .canTxPriority, .rdata(), .prioRegs(), .reqValid(), .reqId(), .reqLevel());
  // expected winner: highest nonzero level, lowest index on ties
  function automatic logic [8:0] arb(input logic [22:0] live, input logic [2:0] ct);
    logic [8:0] w;
    logic [2:0] lv;
    w = 9'h0;
    for (int i = 0; i < 23; i++) begin
      lv = (i == 22) ? ct : mir[PLACE[i][7:4]][PLACE[i][1:0] * 4 +: 3];
      if (live[i] && lv > w[2:0]) w = {1'b1, 5'(i), lv};
    end
    return w;
  endfunction
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 1000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // fixed corners first, then random traffic
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    for (int k = 0; k < 400; k++) begin
      @(negedge core_clk);
      chk("req", {7'h0, e}, {7'h0, reqValid, reqId, reqLevel});
      chk("rdata", er, rdata);
      for (int j = 0; j < 6; j++) chk("prioRegs", mir[j], prioRegs[j]);
      e = arb(srcPending & srcEnable, canTxPriority);
      er = (bus.rd && bus.addr < 3'h6) ? mir[bus.addr] : 16'h0;
      if (bus.wr && bus.addr < 3'h6) mir[bus.addr] = bus.wdata &
        (bus.addr == 3'h0 ? 16'h0777 : (bus.addr == 3'h2 ? 16'h7707 : 16'h7777));
      r = $random(seed);
      @(posedge core_clk);
      bus.addr <= (k < 32) ? k[2:0] : r[4:2];
      bus.wdata <= (k < 8) ? 16'hffff : ((k < 32) ? 16'h0 : r[31:16]);
      bus.wr <= (k < 32) ? !k[3] : (r[1:0] == 2'h0);
      bus.rd <= (k < 32) ? k[3] : (r[1:0] == 2'h1);
      srcPending <= 23'($random(seed));
      srcEnable <= 23'($random(seed)) | 23'($random(seed));
      canTxPriority <= r[7:5];
    end
    tally_and_finish();
  end
endmodule // interrupt_priority_bank_mid_tb
